/* File: inc/rfpc_pkg.sv */
// package for the rf frontend pin control block
package rfpc_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] RFPC_ADDR_AUX_HI = 4'h0;
  localparam logic [3:0] RFPC_ADDR_PAD_HI = 4'h4;
  localparam logic [3:0] RFPC_ADDR_AUX_LO = 4'h8;
  localparam logic [3:0] RFPC_ADDR_PAD_LO = 4'hc;

  // aux settings field positions
  localparam int RFPC_AUX_BYP_BIT = 7;
  localparam int RFPC_AUX_MAP_HI = 6;
  localparam int RFPC_AUX_MAP_LO = 5;
  localparam int RFPC_AUX_EXT_BIT = 4;
  localparam int RFPC_AUX_KEEP_BIT = 3;
  localparam int RFPC_AUX_SETL_BIT = 2;
  localparam int RFPC_AUX_PAV_HI = 1;
  localparam int RFPC_AUX_PAV_LO = 0;
  localparam logic [7:0] RFPC_AUX_RESET = 8'h02;
  localparam logic [7:0] RFPC_AUX_WMASK = 8'hfb;

  // pad config field position and reset
  localparam int RFPC_PAD_HI = 7;
  localparam int RFPC_PAD_LO = 6;
  localparam logic [7:0] RFPC_PAD_RESET = 8'h00;

  // gain word threshold for lna vs bypass
  localparam logic [7:0] RFPC_GAIN_THRESH = 8'h11;
  localparam logic [1:0] RFPC_MAP_NONE = 2'h0;

  // frontend pin configuration
  typedef enum logic [1:0] {
    RFPC_CFG0 = 2'h0,
    RFPC_CFG1 = 2'h1,
    RFPC_CFG2 = 2'h2,
    RFPC_CFG3 = 2'h3
  } rfpc_cfg_type;

  // radio state codes from the radio state machine
  typedef enum logic [2:0] {
    RFPC_ST_OFF = 3'h0,
    RFPC_ST_SLEEP = 3'h1,
    RFPC_ST_RESET = 3'h2,
    RFPC_ST_TX_PREPARE_STATE = 3'h3,
    RFPC_ST_RX = 3'h4,
    RFPC_ST_TX = 3'h5
  } rfpc_radio_type;

  // radio side inputs for one transceiver
  typedef struct packed {
    logic [2:0] state;
    logic [7:0] gain_word;
    logic supply_ok;
  } rfpc_radio_in_type;

  // per transceiver control outputs
  typedef struct packed {
    logic fe_ctrl_a;
    logic fe_ctrl_b;
    logic gain_clear;
    logic ext_gain_zero;
    logic [1:0] agc_gain_map;
    logic reg_enable;
    logic [1:0] pa_supply_select;
  } rfpc_trx_out_type;

  // state of one transceiver channel
  typedef struct packed {
    logic [7:0] aux;
    logic [7:0] pad;
    logic [2:0] prev_state;
    logic settled_s1;
    logic settled_s2;
    rfpc_trx_out_type out;
  } rfpc_chan_type;

endpackage

/* File: hdl/rfpc_top.sv */
// rf frontend pin control for both transceivers with wishbone registers
`timescale 1ns/1ns
`default_nettype none

module rfpc_top
  import rfpc_pkg::*;
(
  input wire logic i_core_clk,                 // core clock 250 mhz
  input wire logic i_reset,                    // async reset, high
  input wire logic i_wb_cyc,                   // wishbone cycle
  input wire logic i_wb_stb,                   // wishbone strobe
  input wire logic i_wb_we,                    // wishbone write
  input wire logic [3:0] i_wb_adr,             // wishbone byte address
  input wire logic [3:0] i_wb_sel,             // wishbone byte select
  input wire logic [31:0] i_wb_dat,            // wishbone write data
  output logic [31:0] o_wb_dat,                // wishbone read data
  output logic o_wb_ack,                       // wishbone acknowledge
  input wire rfpc_radio_in_type i_radio_hi,    // 2.4ghz radio inputs
  input wire rfpc_radio_in_type i_radio_lo,    // sub-1ghz radio inputs
  output logic o_fe_ctrl_a_high_band,          // 2.4ghz frontend a
  output logic o_fe_ctrl_b_high_band,          // 2.4ghz frontend b
  output logic o_fe_ctrl_a_low_band,           // sub-1ghz frontend a
  output logic o_fe_ctrl_b_low_band,           // sub-1ghz frontend b
  output rfpc_trx_out_type o_ctrl_hi,          // 2.4ghz aux controls
  output rfpc_trx_out_type o_ctrl_lo           // sub-1ghz aux controls
);

  // ------------------------------------------------------------------
  // overview
  // ------------------------------------------------------------------
  // each band keeps its own aux and pad byte, its own supply synchroniser
  // and its own copy of the last radio state, so the two transceivers
  // never interact except through the shared bus port.
  // latency: a radio input sampled at one edge shows on the pins and on
  // the control bundle right after that same edge. the extra cycle buys
  // glitch-free pins, since every output leaves a flop.
  // the bus answers every request one cycle later with a single ack
  // pulse; reads of unmapped offsets return zero and are still acked.
  // only byte lane 0 is decoded; a write with sel[0] low is dropped.
  // limitation: with the enable/switch frontend the pins cannot show a
  // bypass code, yet the gain scheme may still report bypass on
  // ext_gain_zero; keep the bypass bit clear with that frontend.
  // the analog supply flag is asynchronous and passes two flops; its
  // read view therefore lags the real supply by two cycles.
  // radio codes outside the known set count as neither rx nor tx, so
  // the pins fall back to their idle levels.
  // the pins are plain levels; nothing here ever drives them as a
  // complementary pair, so any of the four codes may appear.

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    rfpc_chan_type hi;
    rfpc_chan_type lo;
    logic ack;
    logic [31:0] rdat;
  } rfpc_state_type;

  localparam rfpc_trx_out_type OUT_RESET = '{
    fe_ctrl_a: 1'b0,
    fe_ctrl_b: 1'b0,
    gain_clear: 1'b0,
    ext_gain_zero: 1'b0,
    agc_gain_map: RFPC_MAP_NONE,
    reg_enable: 1'b0,
    pa_supply_select: RFPC_AUX_RESET[RFPC_AUX_PAV_HI:RFPC_AUX_PAV_LO]
  };

  localparam rfpc_chan_type CHAN_RESET = '{
    aux: RFPC_AUX_RESET,
    pad: RFPC_PAD_RESET,
    prev_state: RFPC_ST_OFF,
    settled_s1: 1'b0,
    settled_s2: 1'b0,
    out: OUT_RESET
  };

  localparam rfpc_state_type STATE_RESET = '{
    hi: CHAN_RESET,
    lo: CHAN_RESET,
    ack: 1'b0,
    rdat: 32'h0000_0000
  };

  // bit positions of the two levels inside a pin pair word
  localparam int LVL_A_BIT = 1;
  localparam int LVL_B_BIT = 0;

  rfpc_state_type state_ff;
  rfpc_state_type nxt_state;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  // bypass decision for receive; only meaningful when bypass is offered
  function automatic logic bypass_select(
    input logic [7:0] aux,
    input logic [7:0] gain_word
  );
    logic byp_avail;
    logic [1:0] gmap;
    logic use_bypass;
    byp_avail = aux[RFPC_AUX_BYP_BIT];
    gmap = aux[RFPC_AUX_MAP_HI:RFPC_AUX_MAP_LO];
    // map zero with bypass available pins the lna in bypass
    if (byp_avail && (gmap == RFPC_MAP_NONE)) begin
      use_bypass = 1'b1;
    end else if (byp_avail) begin
      // strong signal, low gain word: lna out of the path
      use_bypass = (gain_word <= RFPC_GAIN_THRESH);
    end else begin
      // no bypass path fitted, so the lna is always used
      use_bypass = 1'b0;
    end
    return use_bypass;
  endfunction

  // a/b levels for one configuration, pin a in the upper bit
  // each level is worked out on its own, never as a complementary pair
  function automatic logic [1:0] pin_levels(
    input rfpc_cfg_type cfg,
    input logic is_rx,
    input logic is_tx,
    input logic use_bypass
  );
    logic lvl_a;
    logic lvl_b;
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    unique case (cfg)
      RFPC_CFG0: begin
        // frontend control off: both pins stay low in every state
        lvl_a = 1'b0;
        lvl_b = 1'b0;
      end
      RFPC_CFG1: begin
        // a is the tx/bypass line, b the receive line
        lvl_a = is_tx || (is_rx && use_bypass);
        lvl_b = is_rx;
      end
      RFPC_CFG2: begin
        // b enables the module, a picks tx; no bypass code here
        lvl_a = is_tx;
        lvl_b = is_tx || is_rx;
      end
      RFPC_CFG3: begin
        // outside rx/tx the pins idle at 00; power is the mcu's job
        lvl_a = is_tx;
        lvl_b = is_tx || (is_rx && !use_bypass);
      end
    endcase
    return {lvl_a, lvl_b};
  endfunction

  // analog regulator request for one radio state
  // keeping it on in off costs standby current but speeds the next start
  function automatic logic reg_select(
    input logic [7:0] aux,
    input logic [2:0] state
  );
    logic en;
    if (aux[RFPC_AUX_EXT_BIT] || state == RFPC_ST_SLEEP) begin
      en = 1'b0;
    end else if (state == RFPC_ST_OFF) begin
      en = aux[RFPC_AUX_KEEP_BIT];
    end else begin
      // reset parks the regulator; every active state needs it
      en = (state != RFPC_ST_RESET);
    end
    return en;
  endfunction

  // decode one transceiver's controls from its registered view
  function automatic rfpc_trx_out_type chan_decode(
    input rfpc_chan_type ch,
    input rfpc_radio_in_type rin
  );
    rfpc_trx_out_type o;
    logic use_bypass;
    logic is_rx;
    logic is_tx;
    logic [1:0] lvl;
    o = OUT_RESET;
    is_rx = (rin.state == RFPC_ST_RX);
    is_tx = (rin.state == RFPC_ST_TX);
    use_bypass = bypass_select(ch.aux, rin.gain_word);
    lvl = pin_levels(rfpc_cfg_type'(ch.pad[RFPC_PAD_HI:RFPC_PAD_LO]),
                     is_rx, is_tx, use_bypass);
    o.fe_ctrl_a = lvl[LVL_A_BIT];
    o.fe_ctrl_b = lvl[LVL_B_BIT];
    // gain word restarts only on a transition into receive
    o.gain_clear = is_rx && (ch.prev_state != RFPC_ST_RX);
    // rssi and ed assume no external gain while bypassed
    o.ext_gain_zero = is_rx && use_bypass;
    o.agc_gain_map = ch.aux[RFPC_AUX_MAP_HI:RFPC_AUX_MAP_LO];
    o.reg_enable = reg_select(ch.aux, rin.state);
    o.pa_supply_select = ch.aux[RFPC_AUX_PAV_HI:RFPC_AUX_PAV_LO];
    return o;
  endfunction

  // byte lane 0 write merge, read-only bits kept out
  function automatic logic [7:0] lane_write(
    input logic [7:0] old,
    input logic [7:0] wdat,
    input logic [7:0] wmask
  );
    return (old & ~wmask) | (wdat & wmask);
  endfunction

  // aux read view with live settled status
  function automatic logic [7:0] aux_view(input rfpc_chan_type ch);
    logic [7:0] v;
    v = ch.aux;
    v[RFPC_AUX_SETL_BIT] = ch.settled_s2;
    return v;
  endfunction

  // read view of one mapped register; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(
    input rfpc_state_type st,
    input logic [3:0] adr
  );
    logic [7:0] byte_q;
    unique case (adr)
      RFPC_ADDR_AUX_HI: byte_q = aux_view(st.hi);
      RFPC_ADDR_PAD_HI: byte_q = st.hi.pad;
      RFPC_ADDR_AUX_LO: byte_q = aux_view(st.lo);
      RFPC_ADDR_PAD_LO: byte_q = st.lo.pad;
      default: byte_q = 8'h00;
    endcase
    // upper lanes carry nothing; zero them so reads are defined
    return {24'h00_0000, byte_q};
  endfunction

  // merge one bus write into a channel; only the low lane is stored
  function automatic rfpc_chan_type chan_write(
    input rfpc_chan_type ch,
    input logic is_aux,
    input logic is_pad,
    input logic [7:0] wdat
  );
    rfpc_chan_type c;
    c = ch;
    if (is_aux) begin
      // the settled bit is status, so a write must not touch it
      c.aux = lane_write(ch.aux, wdat, RFPC_AUX_WMASK);
    end
    if (is_pad) begin
      // spare pad bits are kept as plain storage
      c.pad = wdat;
    end
    return c;
  endfunction

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  // bus slave, synchronisers and per channel decode
  always_comb begin
    logic req;
    logic wr;
    nxt_state = state_ff;
    req = i_wb_cyc && i_wb_stb && !state_ff.ack;
    wr = req && i_wb_we && i_wb_sel[0];
    nxt_state.ack = req;
    nxt_state.rdat = 32'h0000_0000;
    // register writes first, so the synchroniser updates below survive
    nxt_state.hi = chan_write(state_ff.hi,
                              wr && (i_wb_adr == RFPC_ADDR_AUX_HI),
                              wr && (i_wb_adr == RFPC_ADDR_PAD_HI),
                              i_wb_dat[7:0]);
    nxt_state.lo = chan_write(state_ff.lo,
                              wr && (i_wb_adr == RFPC_ADDR_AUX_LO),
                              wr && (i_wb_adr == RFPC_ADDR_PAD_LO),
                              i_wb_dat[7:0]);
    // settled status comes from analog, so two flops first
    nxt_state.hi.settled_s1 = i_radio_hi.supply_ok;
    nxt_state.hi.settled_s2 = state_ff.hi.settled_s1;
    nxt_state.lo.settled_s1 = i_radio_lo.supply_ok;
    nxt_state.lo.settled_s2 = state_ff.lo.settled_s1;
    // read data stands with ack for one cycle, zero otherwise
    if (req && !i_wb_we) begin
      nxt_state.rdat = reg_read(state_ff, i_wb_adr);
    end
    // the radio state changes drive the pins with no software step
    nxt_state.hi.out = chan_decode(state_ff.hi, i_radio_hi);
    nxt_state.lo.out = chan_decode(state_ff.lo, i_radio_lo);
    nxt_state.hi.prev_state = i_radio_hi.state;
    nxt_state.lo.prev_state = i_radio_lo.state;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // whole state in one register
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // all outputs straight from flops; two pairs, one per band
  assign o_wb_dat = state_ff.rdat;
  assign o_wb_ack = state_ff.ack;
  assign o_fe_ctrl_a_high_band = state_ff.hi.out.fe_ctrl_a;
  assign o_fe_ctrl_b_high_band = state_ff.hi.out.fe_ctrl_b;
  assign o_fe_ctrl_a_low_band = state_ff.lo.out.fe_ctrl_a;
  assign o_fe_ctrl_b_low_band = state_ff.lo.out.fe_ctrl_b;
  assign o_ctrl_hi = state_ff.hi.out;
  assign o_ctrl_lo = state_ff.lo.out;

endmodule

`default_nettype wire

/* File: test/rfpc_monitor.sv */
// assertion checker for the rf frontend pin control block
`timescale 1ns/1ns
`default_nettype none
module rfpc_monitor
  import rfpc_pkg::*;
(
  input wire logic i_core_clk, // core clock
  input wire logic i_reset, // async reset
  input wire logic i_wb_cyc, // bus cycle
  input wire logic i_wb_stb, // bus strobe
  input wire logic o_wb_ack, // bus answer
  input wire rfpc_radio_in_type i_radio_hi, // high band radio
  input wire logic o_fe_ctrl_a_high_band, // pin a
  input wire logic o_fe_ctrl_b_high_band, // pin b
  input wire rfpc_trx_out_type o_ctrl_hi // high band controls
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // only rx and tx may raise a pin, in any configuration
  logic idle;
  logic [2:0] st;
  assign st = i_radio_hi.state;
  assign idle = !(st inside {RFPC_ST_RX, RFPC_ST_TX});
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // two-cycle holds keep the idle, tx and sleep checks blind to the decode latency
  AST_ACK_ANSWER: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("no ack");
  AST_ACK_PULSE: assert property (
    o_wb_ack |=> !o_wb_ack) else $error("ack too long");
  AST_TX_CODE_ONLY: assert property (
    o_fe_ctrl_a_high_band && !o_fe_ctrl_b_high_band
    |-> $past(st) == RFPC_ST_TX) else $error("a-only code outside tx");
  AST_IDLE_PINS: assert property (
    idle [*2] |=> !o_fe_ctrl_a_high_band && !o_fe_ctrl_b_high_band)
    else $error("pins up while idle");
  AST_TX_NOT_RX: assert property (
    (st == RFPC_ST_TX) [*2]
    |=> o_fe_ctrl_a_high_band || !o_fe_ctrl_b_high_band)
    else $error("tx shows rx code");
  AST_SLEEP_REG: assert property (
    (st == RFPC_ST_SLEEP) [*2] |=> !o_ctrl_hi.reg_enable)
    else $error("regulator on in sleep");
  AST_GAIN_CLEAR: assert property (
    (st != RFPC_ST_RX) ##1 (st == RFPC_ST_RX) |-> ##[1:2] o_ctrl_hi.gain_clear)
    else $error("no gain clear");
  AST_CLEAR_PULSE: assert property (
    o_ctrl_hi.gain_clear |=> !o_ctrl_hi.gain_clear) else $error("clear held");
  AST_EXT_GAIN: assert property (
    o_ctrl_hi.ext_gain_zero |-> $past(st) == RFPC_ST_RX
    || $past(st, 2) == RFPC_ST_RX) else $error("zero gain outside rx");
endmodule
bind rfpc_top rfpc_monitor mon (.i_core_clk, .i_reset, .i_wb_cyc,
  .i_wb_stb, .o_wb_ack, .i_radio_hi, .o_fe_ctrl_a_high_band,
  .o_fe_ctrl_b_high_band, .o_ctrl_hi);
`default_nettype wire

/* File: test/rfpc_fe_model.sv */
// external frontend module model decoding the a/b control pins
`timescale 1ns/1ns
`default_nettype none
module rfpc_fe_model (
  input wire logic i_fe_a, // control pin a
  input wire logic i_fe_b, // control pin b
  input wire logic [1:0] i_cfg, // fitted frontend kind
  input wire logic i_mcu_on, // host power enable
  output logic [1:0] o_mode // 0 off 1 lna 2 tx 3 bypass
);
  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // pins read as two plain levels, never as a pair
  always_comb begin
    case (i_cfg)
      2'h1: o_mode = {i_fe_a, i_fe_b};
      2'h2: o_mode = {i_fe_a, i_fe_a ^ i_fe_b};
      // pins alone cannot power this kind down
      2'h3: o_mode = !i_mcu_on ? 2'h0 :
        (i_fe_a ? {i_fe_b, 1'b0} : {!i_fe_b, 1'b1});
      // unconfigured: raw pins show, so any raised pin is caught
      default: o_mode = {i_fe_a, i_fe_b};
    endcase
  end
endmodule
`default_nettype wire

/* File: test/rf_frontend_pin_control_test.sv */
// self-checking bench for the rf frontend pin control block
`timescale 1ns/1ns
`default_nettype none
module rf_frontend_pin_control_test import rfpc_pkg::*;;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, mcu = 0;
  logic ahi, bhi, alo, blo;
  logic [3:0] adr = 0, sel = 0;
  logic [31:0] wdat = 0, rdat;
  logic [1:0] cfg = 0, mhi, mlo;
  rfpc_radio_in_type rhi = '0, rlo = '0;
  rfpc_trx_out_type chi, clo;
  int bad_count = 0, n_checks = 0;
  // ----------------------------------------
  // clock, design and frontend models
  // ----------------------------------------
  always #2 clk = ~clk;
  rfpc_top dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_radio_hi(rhi),
    .i_radio_lo(rlo), .o_fe_ctrl_a_high_band(ahi),
    .o_fe_ctrl_b_high_band(bhi), .o_fe_ctrl_a_low_band(alo),
    .o_fe_ctrl_b_low_band(blo), .o_ctrl_hi(chi), .o_ctrl_lo(clo));
  rfpc_fe_model fm_hi (.i_fe_a(ahi), .i_fe_b(bhi), .i_cfg(cfg),
    .i_mcu_on(mcu), .o_mode(mhi));
  rfpc_fe_model fm_lo (.i_fe_a(alo), .i_fe_b(blo), .i_cfg(cfg),
    .i_mcu_on(mcu), .o_mode(mlo));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; ack is sampled at the edge, then released
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [7:0] d, output logic [7:0] q);
    int n;
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {2'h3, w, a, 4'h1};
    wdat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    {cyc, stb, we} <= 3'h0;
    if (n >= 20) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  // both bands get the same pad and aux setting
  task automatic setup(input logic [1:0] c, input logic [7:0] aux);
    logic [7:0] q;
    cfg <= c;
    wb(1'b1, RFPC_ADDR_PAD_HI, {c, 6'h0}, q);
    wb(1'b1, RFPC_ADDR_PAD_LO, {c, 6'h0}, q);
    wb(1'b1, RFPC_ADDR_AUX_HI, aux, q);
    wb(1'b1, RFPC_ADDR_AUX_LO, aux, q);
  endtask
  // host powers the frontend only in rx and tx
  task automatic radio(input logic [2:0] s, input logic [7:0] g,
    input logic [1:0] m);
    @(posedge clk);
    {rhi.state, rhi.gain_word, rlo.state, rlo.gain_word} <= {s, g, s, g};
    mcu <= s inside {RFPC_ST_RX, RFPC_ST_TX};
    repeat (4) @(posedge clk);
    #1;
    chk({6'h0, mhi}, {6'h0, m});
    chk({6'h0, mlo}, {6'h0, m});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdc(RFPC_ADDR_AUX_HI, RFPC_AUX_RESET);
    rdc(RFPC_ADDR_PAD_LO, 8'h00);
    rdc(4'h2, 8'h00);
    setup(2'h0, 8'hff);
    rdc(RFPC_ADDR_AUX_LO, 8'hfb);
    {rhi.supply_ok, rlo.supply_ok} <= 2'h3;
    repeat (3) @(posedge clk);
    rdc(RFPC_ADDR_AUX_LO, 8'hff);
    setup(2'h0, 8'h41);
    #1;
    chk({6'h0, clo.agc_gain_map}, 8'h02);
    chk({6'h0, chi.pa_supply_select}, 8'h01);
  endtask
  task automatic t_cfg();
    for (int c = 0; c < 4; c++) begin
      setup(c[1:0], 8'h02);
      for (int s = 0; s < 6; s++)
        radio(s[2:0], 8'h20,
          (c == 0 || s < 4) ? 2'h0 : s[1:0] + 2'h1);
    end
  endtask
  task automatic t_byp();
    setup(2'h1, 8'h20);
    radio(RFPC_ST_RX, 8'h11, 2'h1);
    setup(2'h1, 8'ha0);
    radio(RFPC_ST_RX, 8'h11, 2'h3);
    chk({7'h0, chi.ext_gain_zero}, 8'h01);
    radio(RFPC_ST_RX, 8'h12, 2'h1);
    setup(2'h3, 8'ha0);
    radio(RFPC_ST_RX, 8'h11, 2'h3);
    radio(RFPC_ST_RX, 8'h12, 2'h1);
    setup(2'h1, 8'h80);
    radio(RFPC_ST_RX, 8'h12, 2'h3);
    setup(2'h2, 8'ha0);
    radio(RFPC_ST_RX, 8'h11, 2'h1);
  endtask
  task automatic t_reg();
    setup(2'h0, 8'h00);
    radio(RFPC_ST_OFF, 8'h00, 2'h0);
    chk({7'h0, chi.reg_enable}, 8'h00);
    radio(RFPC_ST_RX, 8'h00, 2'h0);
    chk({7'h0, clo.reg_enable}, 8'h01);
    setup(2'h0, 8'h08);
    radio(RFPC_ST_OFF, 8'h00, 2'h0);
    chk({7'h0, chi.reg_enable}, 8'h01);
    radio(RFPC_ST_SLEEP, 8'h00, 2'h0);
    chk({7'h0, clo.reg_enable}, 8'h00);
    setup(2'h0, 8'h18);
    radio(RFPC_ST_RX, 8'h00, 2'h0);
    chk({7'h0, chi.reg_enable}, 8'h00);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 0;
    t_regs();
    t_cfg();
    t_byp();
    t_reg();
    conclude();
  end
endmodule
`default_nettype wire
